// ===== supply_cmd_pkg.sv
/*
  package for the supply command register block: register addresses,
  command word layout, reset values, timing counts and state types.
  assumes a 20 MHz core clock and a 16-bit register port.
*/
package supply_cmd_pkg;

  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [3:0] CMD_ADDR     = 4'h0;
  localparam logic [3:0] VSET_HI_ADDR = 4'h1;
  localparam logic [3:0] VSET_LO_ADDR = 4'h2;
  localparam logic [3:0] ASET_HI_ADDR = 4'h3;
  localparam logic [3:0] ASET_LO_ADDR = 4'h4;
  localparam logic [3:0] WSET_HI_ADDR = 4'h5;
  localparam logic [3:0] WSET_LO_ADDR = 4'h6;

  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  localparam logic [15:0] CMD_RESET       = 16'h0000;
  localparam logic [15:0] CMD_DEFINED     = 16'h7fff;
  localparam logic [31:0] SETPOINT_RESET  = 32'h0000_0000;
  localparam logic [15:0] READ_UNMAPPED   = 16'h0000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS    = 50;
  localparam int IDLE_TICK_NS     = 1000000;
  localparam int IDLE_TICK_CYCLES = IDLE_TICK_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // command word, bit 15 first
  // ----------------------------------------
  typedef struct packed {
    logic reserved;                // 15
    logic bypass_uses_host_value;  // 14
    logic external_loop;           // 13
    logic host_source;             // 12
    logic watt_input_bypass;       // 11
    logic amp_input_bypass;        // 10
    logic volt_input_bypass;       // 9
    logic energy_clear;            // 8
    logic float_format;            // 7
    logic history_logging_on;      // 6
    logic idle_watch;              // 5
    logic impedance_watch;         // 4
    logic loop_current;            // 3
    logic far_sense_off;           // 2
    logic output_on;               // 1
    logic fault_clear;             // 0
  } cmd_t;

  typedef struct packed {
    logic [31:0] volt;
    logic [31:0] amp;
    logic [31:0] watt;
  } triple_t;

  typedef enum logic [1:0] {
    PWR_OFF   = 2'b00,
    PWR_ON    = 2'b01,
    PWR_FAULT = 2'b10
  } power_state_t;

endpackage

// ===== setpoint_channel.sv
/*
  one setpoint channel: host register pair, saturation, analog refresh
  and override selection.
  assumes hi_wr_in precedes lo_wr_in for a 32-bit write.
*/
module setpoint_channel
  import supply_cmd_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // host write port
  input  wire logic        hi_wr_in,
  input  wire logic        lo_wr_in,
  input  wire logic [15:0] wdata_in,
  // mode
  input  wire logic        analog_mode_in,
  input  wire logic        bypass_in,
  input  wire logic        host_value_in,
  // values
  input  wire logic [31:0] analog_in,
  input  wire logic [31:0] max_in,
  output logic      [31:0] reg_out,
  output logic      [31:0] setpoint_out
);

  logic [15:0] staged_hi;
  logic [31:0] written;
  logic        keep_host;

  assign written   = {staged_hi, wdata_in};
  // host value wins only for an overridden input with saturation off
  assign keep_host = bypass_in && host_value_in;

  // ----------------------------------------
  // register pair
  // ----------------------------------------
  // [RQ22] high half staged
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      staged_hi <= 16'h0000;
    else if (hi_wr_in)
      staged_hi <= wdata_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      reg_out <= SETPOINT_RESET;
    // [RQ17] analog refresh, writes dropped
    else if (analog_mode_in && !keep_host)
      reg_out <= analog_in;
    // [RQ18] saturate at limit
    else if (lo_wr_in)
      reg_out <= (written > max_in) ? max_in : written;
  end

  // ----------------------------------------
  // setpoint selection
  // ----------------------------------------
  // [RQ19] analog input, maximum or register
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      setpoint_out <= SETPOINT_RESET;
    else if (!analog_mode_in)
      setpoint_out <= reg_out;
    // [RQ16] register instead of maximum
    else if (bypass_in)
      setpoint_out <= host_value_in ? reg_out : max_in;
    else
      setpoint_out <= analog_in;
  end

endmodule // setpoint_channel

// ===== supply_command_register.sv
/*
  command register bank of a programmable dc supply, with the three
  setpoint channels it steers.
  assumes a synchronous 16-bit register port driven by the link
  front end, and analog values already converted to 32-bit words.
*/
// Operation
// [RQ1] power stages on only with output enable
// [RQ2] fault clear bit erases history, self-clears
// [RQ3] far sense off drops sensing and monitors
// [RQ4] loop current bit selects 4-20mA, else 0-10V
// [RQ5] impedance watch raises faults outside limits
// [RQ6] bus idle watch faults after idle period
// [RQ7] float bit: ieee float, else scaled integer
// [RQ8] history logging bit enables periodic recording
// [RQ9] energy clear bit rising resets accumulator
// [RQ10] volt bypass forces voltage setpoint maximum
// [RQ11] amp bypass forces current setpoint maximum
// [RQ12] watt bypass forces power setpoint maximum
// [RQ13] host source bit: digital, else analog
// [RQ14] digital mode, enable low at turn-on faults
// [RQ15] external loop uses power input feedback
// [RQ16] saturation off uses register, not maximum
// [RQ17] analog mode refreshes registers, drops writes
// [RQ18] over-limit writes store the maximum
// [RQ19] three modes, each with one source
// [RQ20] command at 0x0, bit 1 output on
// [RQ21] bit 7 selects float format
// [RQ22] setpoint pairs: high then low half
// [RQ23] reserved bits read zero, ignore writes
module supply_command_register
  import supply_cmd_pkg::*;
#(
  parameter int TICK_CYCLES = IDLE_TICK_CYCLES
)
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // register port
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  output logic      [15:0] rdata_out,
  output logic             rvalid_out,
  // analog interface
  input  wire triple_t     analog_in,
  input  wire triple_t     max_in,
  input  wire logic        ext_enable_in,
  // monitors
  input  wire logic        zout_bad_in,
  input  wire logic        zcable_bad_in,
  input  wire logic        bus_activity_in,
  input  wire logic [15:0] idle_limit_in,
  // control outputs
  output logic             power_stage_on_out,
  output logic             fault_clear_out,
  output logic             energy_clear_out,
  output logic             far_sense_on_out,
  output logic             cable_monitor_on_out,
  output logic             loop_current_out,
  output logic             float_format_out,
  output logic             history_logging_out,
  output logic             process_mode_out,
  output logic      [31:0] process_feedback_out,
  // faults
  output logic             impedance_fault_out,
  output logic             idle_fault_out,
  output logic             enable_fault_out,
  // setpoints
  output triple_t          setpoint_out
);

  cmd_t         cmd;
  cmd_t         wr_cmd;
  power_state_t state;
  power_state_t next_state;
  triple_t      sp_reg;
  logic         cmd_wr;
  logic         fault_clr_rise;
  logic         energy_rise;
  logic         analog_mode;
  logic [15:0]  tick_cnt;
  logic         tick;
  logic [15:0]  idle_ms;
  logic         z_bad;

  // ----------------------------------------
  // command register
  // ----------------------------------------
  // [RQ20] command at address zero
  assign cmd_wr = wr_en_in && (addr_in == CMD_ADDR);
  // [RQ23] reserved bits dropped
  assign wr_cmd = cmd_t'(wdata_in & CMD_DEFINED);
  // [RQ2] rising edge of fault clear
  assign fault_clr_rise = cmd_wr && wr_cmd.fault_clear && !cmd.fault_clear;
  // [RQ9] rising edge of energy clear
  assign energy_rise = cmd_wr && wr_cmd.energy_clear && !cmd.energy_clear;
  // [RQ13] zero means analog source
  assign analog_mode = !cmd.host_source;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      cmd <= cmd_t'(CMD_RESET);
    else if (cmd_wr)
      cmd <= wr_cmd;
    // [RQ2] bit returns to zero
    else if (cmd.fault_clear)
      cmd.fault_clear <= 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      fault_clear_out  <= 1'b0;
      energy_clear_out <= 1'b0;
    end
    else
    begin
      fault_clear_out  <= fault_clr_rise;
      energy_clear_out <= energy_rise;
    end
  end

  // ----------------------------------------
  // mode outputs
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      far_sense_on_out     <= 1'b0;
      cable_monitor_on_out <= 1'b0;
      loop_current_out     <= 1'b0;
      float_format_out     <= 1'b0;
      history_logging_out  <= 1'b0;
      process_mode_out     <= 1'b0;
      process_feedback_out <= SETPOINT_RESET;
    end
    else
    begin
      // [RQ3] sensing and its monitors
      far_sense_on_out     <= !cmd.far_sense_off;
      cable_monitor_on_out <= !cmd.far_sense_off && cmd.impedance_watch;
      // [RQ4] current or voltage signalling
      loop_current_out     <= cmd.loop_current;
      // [RQ7] [RQ21] number format
      float_format_out     <= cmd.float_format;
      // [RQ8] recorder enable
      history_logging_out  <= cmd.history_logging_on;
      // [RQ15] power input as feedback
      process_mode_out     <= cmd.external_loop;
      process_feedback_out <= cmd.external_loop ? analog_in.watt : SETPOINT_RESET;
    end
  end

  // ----------------------------------------
  // output enable sequence
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      PWR_OFF:
        // [RQ14] digital mode needs enable high
        if (cmd.output_on)
          next_state = (cmd.host_source && !ext_enable_in) ? PWR_FAULT : PWR_ON;
      PWR_ON:
        if (!cmd.output_on)
          next_state = PWR_OFF;
      PWR_FAULT:
        if (!cmd.output_on)
          next_state = PWR_OFF;
      default:
        next_state = PWR_OFF;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      state <= PWR_OFF;
    else
      state <= next_state;
  end

  // [RQ1] stages follow enabled state only
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      power_stage_on_out <= 1'b0;
    else
      power_stage_on_out <= (next_state == PWR_ON);
  end

  // ----------------------------------------
  // fault flags
  // ----------------------------------------
  // [RQ3] [RQ5] cable check needs far sensing
  assign z_bad = cmd.impedance_watch && (zout_bad_in || (zcable_bad_in && !cmd.far_sense_off));

  // set beats clear so an event in the clear cycle survives
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      impedance_fault_out <= 1'b0;
      enable_fault_out    <= 1'b0;
    end
    else
    begin
      // [RQ5] impedance window fault
      if (z_bad)
        impedance_fault_out <= 1'b1;
      else if (fault_clr_rise)
        impedance_fault_out <= 1'b0;
      // [RQ14] turn-on fault
      if (state == PWR_OFF && next_state == PWR_FAULT)
        enable_fault_out <= 1'b1;
      else if (fault_clr_rise)
        enable_fault_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // bus idle watchdog
  // ----------------------------------------
  // millisecond enable; shorten TICK_CYCLES in simulation
  assign tick = (tick_cnt == 16'(TICK_CYCLES - 1));

  always_ff @(posedge clk_in)
  begin
    if (srst_in || tick)
      tick_cnt <= 16'h0000;
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  // [RQ6] idle time since last traffic
  always_ff @(posedge clk_in)
  begin
    if (srst_in || bus_activity_in || !cmd.idle_watch)
      idle_ms <= 16'h0000;
    else if (tick && idle_ms != 16'hffff)
      idle_ms <= idle_ms + 16'h0001;
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      idle_fault_out <= 1'b0;
    // [RQ6] limit of zero never trips
    else if (cmd.idle_watch && idle_limit_in != 16'h0000 && idle_ms >= idle_limit_in)
      idle_fault_out <= 1'b1;
    else if (fault_clr_rise)
      idle_fault_out <= 1'b0;
  end

  // ----------------------------------------
  // setpoint channels
  // ----------------------------------------
  // [RQ10] voltage channel
  setpoint_channel u_volt (
    .clk_in         (clk_in),
    .srst_in        (srst_in),
    .hi_wr_in       (wr_en_in && addr_in == VSET_HI_ADDR),
    .lo_wr_in       (wr_en_in && addr_in == VSET_LO_ADDR),
    .wdata_in       (wdata_in),
    .analog_mode_in (analog_mode),
    .bypass_in      (cmd.volt_input_bypass),
    .host_value_in  (cmd.bypass_uses_host_value),
    .analog_in      (analog_in.volt),
    .max_in         (max_in.volt),
    .reg_out        (sp_reg.volt),
    .setpoint_out   (setpoint_out.volt)
  );

  // [RQ11] current channel
  setpoint_channel u_amp (
    .clk_in         (clk_in),
    .srst_in        (srst_in),
    .hi_wr_in       (wr_en_in && addr_in == ASET_HI_ADDR),
    .lo_wr_in       (wr_en_in && addr_in == ASET_LO_ADDR),
    .wdata_in       (wdata_in),
    .analog_mode_in (analog_mode),
    .bypass_in      (cmd.amp_input_bypass),
    .host_value_in  (cmd.bypass_uses_host_value),
    .analog_in      (analog_in.amp),
    .max_in         (max_in.amp),
    .reg_out        (sp_reg.amp),
    .setpoint_out   (setpoint_out.amp)
  );

  // [RQ12] power channel
  setpoint_channel u_watt (
    .clk_in         (clk_in),
    .srst_in        (srst_in),
    .hi_wr_in       (wr_en_in && addr_in == WSET_HI_ADDR),
    .lo_wr_in       (wr_en_in && addr_in == WSET_LO_ADDR),
    .wdata_in       (wdata_in),
    .analog_mode_in (analog_mode),
    .bypass_in      (cmd.watt_input_bypass),
    .host_value_in  (cmd.bypass_uses_host_value),
    .analog_in      (analog_in.watt),
    .max_in         (max_in.watt),
    .reg_out        (sp_reg.watt),
    .setpoint_out   (setpoint_out.watt)
  );

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rdata_out  <= READ_UNMAPPED;
      rvalid_out <= 1'b0;
    end
    else
    begin
      rvalid_out <= rd_en_in;
      // [RQ23] reserved bits read zero
      if (addr_in == CMD_ADDR)
        rdata_out <= 16'(cmd) & CMD_DEFINED;
      else if (addr_in == VSET_HI_ADDR)
        rdata_out <= sp_reg.volt[31:16];
      else if (addr_in == VSET_LO_ADDR)
        rdata_out <= sp_reg.volt[15:0];
      else if (addr_in == ASET_HI_ADDR)
        rdata_out <= sp_reg.amp[31:16];
      else if (addr_in == ASET_LO_ADDR)
        rdata_out <= sp_reg.amp[15:0];
      else if (addr_in == WSET_HI_ADDR)
        rdata_out <= sp_reg.watt[31:16];
      else if (addr_in == WSET_LO_ADDR)
        rdata_out <= sp_reg.watt[15:0];
      else
        rdata_out <= READ_UNMAPPED;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  a_stage_needs_on: assert property ( // [RQ1]
    power_stage_on_out |-> $past(cmd.output_on))
    else $error("power stage on without output enable");
  a_clear_self_zero: assert property ( // [RQ2]
    fault_clr_rise ##1 !wr_en_in |=> !cmd.fault_clear && $past(fault_clear_out))
    else $error("fault clear bit did not self clear");
  a_sense_follows: assert property ( // [RQ3]
    cmd.far_sense_off |=> !far_sense_on_out && !cable_monitor_on_out)
    else $error("far sensing still used");
  a_z_fault_set: assert property ( // [RQ5]
    z_bad |=> impedance_fault_out)
    else $error("impedance fault missed");
  a_z_fault_quiet: assert property ( // [RQ5]
    !cmd.impedance_watch && !impedance_fault_out && !fault_clr_rise |=> !impedance_fault_out)
    else $error("impedance fault while disabled");
  a_enable_fault: assert property ( // [RQ14]
    state == PWR_OFF && cmd.output_on && cmd.host_source && !ext_enable_in
      |=> enable_fault_out && !power_stage_on_out)
    else $error("turn-on without enable not faulted");
  a_energy_pulse: assert property ( // [RQ9]
    energy_rise |=> energy_clear_out ##1 (!energy_clear_out || $past(energy_rise)))
    else $error("energy clear pulse wrong");
  a_digital_sat: assert property ( // [RQ18]
    !analog_mode && $past(!analog_mode) && $past(!analog_mode, 2)
      |-> sp_reg.volt <= $past(max_in.volt) || $stable(sp_reg.volt))
    else $error("voltage register above limit");
  a_volt_bypass: assert property ( // [RQ10]
    analog_mode && cmd.volt_input_bypass && !cmd.bypass_uses_host_value
      |=> setpoint_out.volt == $past(max_in.volt))
    else $error("voltage bypass not at maximum");
  a_reserved_zero: assert property ( // [RQ23]
    rvalid_out && $past(addr_in) == CMD_ADDR |-> !rdata_out[15])
    else $error("reserved bit read non-zero");
  a_format_out: assert property ( // [RQ21]
    cmd.float_format |=> float_format_out)
    else $error("float format not driven");

  c_turn_on: cover property (state == PWR_OFF ##1 state == PWR_ON);
  c_enable_fault: cover property (enable_fault_out ##[1:20] fault_clear_out);
  c_idle_fault: cover property (!idle_fault_out ##1 idle_fault_out);
  c_host_write: cover property (wr_en_in && addr_in == VSET_LO_ADDR && !analog_mode);

endmodule // supply_command_register

// ===== supply_host_model.sv
/*
  host controller model for the supply command register: drives the
  register port with whole write and read transfers.
  assumes one clock shared with the block and a one-cycle read answer.
*/
module supply_host_model
  import supply_cmd_pkg::*;
(
  // clock
  input  wire logic        clk_in,
  // register port
  output logic             wr_en_out,
  output logic             rd_en_out,
  output logic      [3:0]  addr_out,
  output logic      [15:0] wdata_out,
  input  wire logic [15:0] rdata_in,
  input  wire logic        rvalid_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  initial
  begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out  = 4'hf;
    wdata_out = 16'h0000;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_en_out <= 1'b1;
    addr_out  <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_en_out <= 1'b0;
    // released data shows the inverse, never a stale copy
    wdata_out <= ~d;
  endtask

  // value already in the selected format
  task automatic wr32(input logic [3:0] a, input logic [31:0] v);
    wr(a, v[31:16]);
    wr(a + 4'h1, v[15:0]);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk_in);
    rd_en_out <= 1'b1;
    addr_out  <= a;
    @(posedge clk_in);
    rd_en_out <= 1'b0;
    #1;
    d  = rdata_in;
    ok = rvalid_in;
  endtask
endmodule // supply_host_model

// ===== tb_supply_command_register.sv
/*
  self-checking bench for the supply command register with a host model.
  assumes the design package and a short idle tick parameter.
*/
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end
module tb_supply_command_register
  import supply_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 4;
  logic        clk_in = 1'b0;
  logic        srst_in, wr_en, rd_en, rvalid, ok;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, idle_limit_in, d;
  triple_t     analog_in, max_in, setpoint_out;
  logic        ext_enable_in, zout_bad_in, zcable_bad_in, bus_activity_in;
  logic        pwr, fcl, ecl, fsense, cmon, loopc, flt, hist, proc, zf, idf, enf;
  logic [31:0] fb, v;
  int          num_errors, compares, seed, fc_n, ec_n, n0, n1;
  int          bits [4] = '{3, 6, 7, 13};

  always #25 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    fc_n <= fc_n + int'(fcl);
    ec_n <= ec_n + int'(ecl);
  end

  supply_host_model i_host (.clk_in(clk_in), .wr_en_out(wr_en), .rd_en_out(rd_en),
    .addr_out(addr), .wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));
  supply_command_register #(.TICK_CYCLES(TICKS)) i_dut (.clk_in(clk_in),
    .srst_in(srst_in), .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr),
    .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(rvalid), .analog_in(analog_in),
    .max_in(max_in), .ext_enable_in(ext_enable_in), .zout_bad_in(zout_bad_in),
    .zcable_bad_in(zcable_bad_in), .bus_activity_in(bus_activity_in),
    .idle_limit_in(idle_limit_in), .power_stage_on_out(pwr), .fault_clear_out(fcl),
    .energy_clear_out(ecl), .far_sense_on_out(fsense), .cable_monitor_on_out(cmon),
    .loop_current_out(loopc), .float_format_out(flt), .history_logging_out(hist),
    .process_mode_out(proc), .process_feedback_out(fb), .impedance_fault_out(zf),
    .idle_fault_out(idf), .enable_fault_out(enf), .setpoint_out(setpoint_out));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] pick(triple_t t, int k);
    return (k == 0) ? t.volt : (k == 1) ? t.amp : t.watt;
  endfunction
  function automatic logic [31:0] sat(logic [31:0] x, logic [31:0] m);
    return (x > m) ? m : x;
  endfunction
  task automatic cyc(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // two-cycle stage lag plus margin
  task automatic setc(logic [15:0] c);
    i_host.wr(CMD_ADDR, c);
    cyc(3);
  endtask
  task automatic sp(int k, logic [31:0] x);
    i_host.wr32(4'(1 + 2 * k), x);
    cyc(3);
    `CHK(pick(setpoint_out, k), sat(x, pick(max_in, k)))
  endtask
  task automatic wrap_up;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    #(50 * 8000);
    num_errors++;
    wrap_up;
  end

  initial
  begin
    seed = 32'hedbc;
    fc_n = 0;
    ec_n = 0;
    srst_in = 1'b1;
    analog_in = '0;
    max_in = {32'h0000_8000, 32'h0000_8000, 32'h0000_8000};
    ext_enable_in = 1'b1;
    zout_bad_in = 1'b0;
    zcable_bad_in = 1'b0;
    bus_activity_in = 1'b1;
    idle_limit_in = 16'h0003;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    i_host.rd(CMD_ADDR, d, ok);
    `CHK({ok, d}, {1'b1, CMD_RESET})
    i_host.wr(CMD_ADDR, 16'h9000);
    i_host.rd(CMD_ADDR, d, ok);
    `CHK(d, 16'h1000)
    i_host.rd(4'h7, d, ok);
    `CHK(d, READ_UNMAPPED)
    $display("test registers done");
    setc(16'h1002);
    `CHK({pwr, enf}, 2'b10)
    setc(16'h1000);
    `CHK(pwr, 1'b0)
    ext_enable_in <= 1'b0;
    setc(16'h1002);
    `CHK({pwr, enf}, 2'b01)
    setc(16'h1000);
    ext_enable_in <= 1'b1;
    n0 = fc_n;
    setc(16'h1001);
    `CHK({fc_n - n0, enf}, {32'd1, 1'b0})
    i_host.rd(CMD_ADDR, d, ok);
    `CHK(d, 16'h1000)
    n0 = ec_n;
    setc(16'h1100);
    setc(16'h1100);
    `CHK(ec_n - n0, 1)
    $display("test events done");
    zcable_bad_in <= 1'b1;
    setc(16'h1014);
    `CHK({fsense, cmon, zf}, 3'b000)
    setc(16'h1010);
    `CHK({fsense, cmon, zf}, 3'b111)
    zcable_bad_in <= 1'b0;
    setc(16'h1000);
    zout_bad_in <= 1'b1;
    setc(16'h1001);
    `CHK(zf, 1'b0)
    setc(16'h1010);
    `CHK(zf, 1'b1)
    zout_bad_in <= 1'b0;
    setc(16'h1021);
    cyc(8 * TICKS);
    `CHK(idf, 1'b0)
    bus_activity_in <= 1'b0;
    cyc(5 * TICKS);
    `CHK(idf, 1'b1)
    bus_activity_in <= 1'b1;
    setc(16'h1001);
    $display("test monitors done");
    analog_in <= {$random(seed), $random(seed), $random(seed)};
    for (int i = 0; i < 4; i++)
    begin
      setc(16'h1000 | (16'h0001 << bits[i]));
      `CHK({loopc, hist, flt, proc}, 4'b1000 >> i)
      `CHK(fb, (i == 3) ? analog_in.watt : 32'h0)
    end
    $display("test modes done");
    for (int k = 0; k < 3; k++)
    begin
      sp(k, pick(max_in, k));
      sp(k, pick(max_in, k) + 32'h1);
      sp(k, 32'h0);
    end
    for (int i = 0; i < 9; i++)
      sp(i % 3, 32'($random(seed)) & 32'h0000_ffff);
    $display("test setpoints done");
    setc(16'h0000);
    `CHK(setpoint_out, analog_in)
    i_host.wr32(VSET_HI_ADDR, 32'h0000_0001);
    cyc(3);
    `CHK(setpoint_out.volt, analog_in.volt)
    // register itself must hold the analog value, not the dropped write
    i_host.rd(VSET_LO_ADDR, d, ok);
    `CHK(d, analog_in.volt[15:0])
    for (int k = 0; k < 3; k++)
    begin
      setc(16'h0200 << k);
      `CHK(pick(setpoint_out, k), pick(max_in, k))
      `CHK(pick(setpoint_out, (k + 1) % 3), pick(analog_in, (k + 1) % 3))
    end
    setc(16'h4200);
    i_host.wr32(VSET_HI_ADDR, 32'h0000_1234);
    cyc(3);
    `CHK(setpoint_out.volt, 32'h0000_1234)
    i_host.rd(VSET_LO_ADDR, d, ok);
    `CHK({ok, d}, {1'b1, 16'h1234})
    $display("test analog done");
    wrap_up;
  end
endmodule // tb_supply_command_register
